// ---- verilog/cimc_regs.vh ----
// Register map constants for the charger mask and converter control bank.
// Assumes a byte-wide register port addressed by an 8-bit register index.
`ifndef CIMC_REGS_VH
`define CIMC_REGS_VH

// ==========================================================
// Offsets
`define CIMC_OFF_CHG_MASK_B   8'h13
`define CIMC_OFF_FAULT_MASK   8'h14
`define CIMC_OFF_CONV_CTRL    8'h15
`define CIMC_OFF_CHAN_DIS     8'h16

// ==========================================================
// Reset values
`define CIMC_RST_CHG_MASK_B   8'h00
`define CIMC_RST_FAULT_MASK   8'h00
`define CIMC_RST_CONV_CTRL    8'h30
`define CIMC_RST_CHAN_DIS     8'h02

// ==========================================================
// Writable bit masks (reserved bits excluded)
`define CIMC_WMASK_CHG_MASK_B 8'h97
`define CIMC_WMASK_FAULT_MASK 8'hF9
`define CIMC_WMASK_CONV_CTRL  8'hF0
`define CIMC_WMASK_CHAN_DIS   8'hFD
// Bits that always read as one
`define CIMC_ONES_CHAN_DIS    8'h02

// ==========================================================
// Field positions, charger mask two
`define CIMC_B_PG             7
`define CIMC_B_VBUS           4
`define CIMC_B_TS             2
`define CIMC_B_ICO            1
`define CIMC_B_VSYS           0
// Field positions, fault mask
`define CIMC_B_OVP            7
`define CIMC_B_TSHUT          6
`define CIMC_B_BATOVP         5
`define CIMC_B_TMR            4
`define CIMC_B_SHORT          3
`define CIMC_B_BUCK           0
// Field positions, converter control
`define CIMC_B_CONV_EN        7
`define CIMC_B_CONV_RATE      6
`define CIMC_B_SAMP_HI        5
`define CIMC_B_SAMP_LO        4

// ==========================================================
// Event vector: index of each event source
`define CIMC_NEV              11
`define CIMC_EV_PG            0
`define CIMC_EV_VBUS          1
`define CIMC_EV_TS            2
`define CIMC_EV_ICO           3
`define CIMC_EV_VSYS          4
`define CIMC_EV_OVP           5
`define CIMC_EV_TSHUT         6
`define CIMC_EV_BATOVP        7
`define CIMC_EV_TMR           8
`define CIMC_EV_SHORT         9
`define CIMC_EV_BUCK          10

// Effective resolutions per sample-speed code
`define CIMC_RES_00           4'hF
`define CIMC_RES_01           4'hE
`define CIMC_RES_10           4'hD
`define CIMC_RES_11           4'hC

`endif

// ---- verilog/cimc_sync.v ----
// Two-flop synchroniser for a vector of status levels from the analog side.
// Assumes the inputs are quasi-static levels, not multi-bit words needing coherence.
`default_nettype none

module cimc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rstn,
    // Data
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] stab_ff;

    // First stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (!rstn) begin
            meta_ff <= {W{1'b0}};
            stab_ff <= {W{1'b0}};
        end else begin
            meta_ff <= async_in;
            stab_ff <= meta_ff;
        end
    end

    assign sync_out = stab_ff;

endmodule

`default_nettype wire

// ---- verilog/cimc_event_det.v ----
// Change and rising-edge detector for the synchronised status inputs.
// Assumes its inputs are already synchronous to clk_sys.
`default_nettype none

`include "cimc_regs.vh"

module cimc_event_det (
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 rstn,
    // Synchronised status
    input  wire                 power_good,
    input  wire [2:0]           input_bus_state,
    input  wire [2:0]           thermistor_state,
    input  wire                 optimizer_state,
    input  wire                 min_system_voltage,
    input  wire                 input_overvolt,
    input  wire                 thermal_shutdown,
    input  wire                 battery_overvolt,
    input  wire                 safety_timer_expired,
    input  wire                 system_short,
    input  wire                 buck_fault_state,
    // One-cycle event pulses
    output wire [`CIMC_NEV-1:0] event_pulse
);

    localparam SW = 15;

    wire [SW-1:0] cur_w;
    reg  [SW-1:0] prev_ff;
    reg           armed_ff;

    assign cur_w = {buck_fault_state, system_short, safety_timer_expired, battery_overvolt,
                    thermal_shutdown, input_overvolt, min_system_voltage, optimizer_state,
                    thermistor_state, input_bus_state, power_good};

    // Armed flag keeps the first sample after reset from looking like an event
    always @(posedge clk_sys) begin
        if (!rstn) begin
            prev_ff  <= {SW{1'b0}};
            armed_ff <= 1'b0;
        end else begin
            prev_ff  <= cur_w;
            armed_ff <= 1'b1;
        end
    end

    wire [SW-1:0] chg_w  = (cur_w ^ prev_ff) & {SW{armed_ff}};
    wire [SW-1:0] rise_w = cur_w & ~prev_ff & {SW{armed_ff}};

    assign event_pulse[`CIMC_EV_PG]     = chg_w[0];
    assign event_pulse[`CIMC_EV_VBUS]   = |chg_w[3:1];
    assign event_pulse[`CIMC_EV_TS]     = |chg_w[6:4];
    assign event_pulse[`CIMC_EV_ICO]    = rise_w[7];
    assign event_pulse[`CIMC_EV_VSYS]   = chg_w[8];
    assign event_pulse[`CIMC_EV_OVP]    = rise_w[9];
    assign event_pulse[`CIMC_EV_TSHUT]  = rise_w[10];
    assign event_pulse[`CIMC_EV_BATOVP] = rise_w[11];
    assign event_pulse[`CIMC_EV_TMR]    = rise_w[12];
    assign event_pulse[`CIMC_EV_SHORT]  = rise_w[13];
    // Buck fault is a rising edge of its own level
    assign event_pulse[`CIMC_EV_BUCK]   = rise_w[SW-1];

endmodule

`default_nettype wire

// ---- verilog/cimc_bank.v ----
// Interrupt mask and converter control register bank of a battery charger.
// Assumes a byte register port from the serial control slave, status levels from
// the analog side on pins, and a one-cycle watchdog expiry pulse on clk_sys.
`default_nettype none

`include "cimc_regs.vh"

module cimc_bank (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Register reset and watchdog expiry, one-cycle pulses on clk_sys
    input  wire        reg_reset,
    input  wire        watchdog_expired,
    // Register port from the serial control slave
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_hit,
    // Status levels from pins
    input  wire        power_good,
    input  wire [2:0]  input_bus_state,
    input  wire [2:0]  thermistor_state,
    input  wire        optimizer_state,
    input  wire        min_system_voltage,
    input  wire        input_overvolt,
    input  wire        thermal_shutdown,
    input  wire        battery_overvolt,
    input  wire        safety_timer_expired,
    input  wire        system_short,
    input  wire        buck_fault_state,
    // Interrupt and event flags
    output reg         irq_pulse,
    output reg  [10:0] event_seen,
    // Converter control to the measurement sequencer
    output wire        conv_enable,
    output wire        conv_one_shot,
    output reg  [3:0]  conv_resolution,
    output wire [7:0]  chan_off
);

    // ==========================================================
    // Register storage
    reg  [7:0] chg_mask_b_ff;
    reg  [7:0] fault_mask_ff;
    reg  [7:0] conv_ctrl_ff;
    reg  [7:0] chan_dis_ff;
    wire [`CIMC_NEV-1:0] event_pulse;
    wire [`CIMC_NEV-1:0] block_vec;

    function wr_hit;
        input [7:0] addr;
        input [7:0] off;
        input       wr;
        begin
            wr_hit = wr && (addr == off);
        end
    endfunction

    // Only writable bits are stored; reserved bits are forced by the masks
    always @(posedge clk_sys) begin
        if (!rstn || reg_reset) begin
            chg_mask_b_ff <= `CIMC_RST_CHG_MASK_B;
            fault_mask_ff <= `CIMC_RST_FAULT_MASK;
            conv_ctrl_ff  <= `CIMC_RST_CONV_CTRL;
            chan_dis_ff   <= `CIMC_RST_CHAN_DIS;
        end else begin
            if (wr_hit(reg_addr, `CIMC_OFF_CHG_MASK_B, reg_wr))
                chg_mask_b_ff <= reg_wdata & `CIMC_WMASK_CHG_MASK_B;
            if (wr_hit(reg_addr, `CIMC_OFF_FAULT_MASK, reg_wr))
                fault_mask_ff <= reg_wdata & `CIMC_WMASK_FAULT_MASK;
            if (wr_hit(reg_addr, `CIMC_OFF_CONV_CTRL, reg_wr))
                conv_ctrl_ff  <= reg_wdata & `CIMC_WMASK_CONV_CTRL;
            if (wr_hit(reg_addr, `CIMC_OFF_CHAN_DIS, reg_wr))
                chan_dis_ff   <= (reg_wdata & `CIMC_WMASK_CHAN_DIS) | `CIMC_ONES_CHAN_DIS;
            // Watchdog wins over a same-cycle write, keeping the converter safely off
            if (watchdog_expired)
                conv_ctrl_ff[`CIMC_B_CONV_EN] <= 1'b0;
        end
    end

    // ==========================================================
    // Read path
    always @* begin
        reg_rdata = 8'h00;
        reg_hit   = 1'b1;
        if (reg_addr == `CIMC_OFF_CHG_MASK_B)
            reg_rdata = chg_mask_b_ff & `CIMC_WMASK_CHG_MASK_B;
        else if (reg_addr == `CIMC_OFF_FAULT_MASK)
            reg_rdata = fault_mask_ff & `CIMC_WMASK_FAULT_MASK;
        else if (reg_addr == `CIMC_OFF_CONV_CTRL)
            reg_rdata = conv_ctrl_ff & `CIMC_WMASK_CONV_CTRL;
        else if (reg_addr == `CIMC_OFF_CHAN_DIS)
            reg_rdata = chan_dis_ff | `CIMC_ONES_CHAN_DIS;
        else
            reg_hit   = 1'b0;
    end

    // ==========================================================
    // Converter control outputs
    assign conv_enable   = conv_ctrl_ff[`CIMC_B_CONV_EN];
    assign conv_one_shot = conv_ctrl_ff[`CIMC_B_CONV_RATE];
    assign chan_off      = chan_dis_ff & `CIMC_WMASK_CHAN_DIS;

    always @* begin
        case ({conv_ctrl_ff[`CIMC_B_SAMP_HI], conv_ctrl_ff[`CIMC_B_SAMP_LO]})
            2'b00:   conv_resolution = `CIMC_RES_00;
            2'b01:   conv_resolution = `CIMC_RES_01;
            2'b10:   conv_resolution = `CIMC_RES_10;
            default: conv_resolution = `CIMC_RES_11;
        endcase
    end

    // ==========================================================
    // Status synchronisation and event detection
    wire [14:0] st_sync;

    cimc_sync #(
        .W (15)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({buck_fault_state, system_short, safety_timer_expired, battery_overvolt,
                    thermal_shutdown, input_overvolt, min_system_voltage, optimizer_state,
                    thermistor_state, input_bus_state, power_good}),
        .sync_out (st_sync)
    );

    cimc_event_det u_det (
        .clk_sys              (clk_sys),
        .rstn                 (rstn),
        .power_good           (st_sync[0]),
        .input_bus_state      (st_sync[3:1]),
        .thermistor_state     (st_sync[6:4]),
        .optimizer_state      (st_sync[7]),
        .min_system_voltage   (st_sync[8]),
        .input_overvolt       (st_sync[9]),
        .thermal_shutdown     (st_sync[10]),
        .battery_overvolt     (st_sync[11]),
        .safety_timer_expired (st_sync[12]),
        .system_short         (st_sync[13]),
        .buck_fault_state     (st_sync[14]),
        .event_pulse          (event_pulse)
    );

    // ==========================================================
    // Masking and interrupt merge
    assign block_vec[`CIMC_EV_PG]     = chg_mask_b_ff[`CIMC_B_PG];
    assign block_vec[`CIMC_EV_VBUS]   = chg_mask_b_ff[`CIMC_B_VBUS];
    assign block_vec[`CIMC_EV_TS]     = chg_mask_b_ff[`CIMC_B_TS];
    assign block_vec[`CIMC_EV_ICO]    = chg_mask_b_ff[`CIMC_B_ICO];
    assign block_vec[`CIMC_EV_VSYS]   = chg_mask_b_ff[`CIMC_B_VSYS];
    assign block_vec[`CIMC_EV_OVP]    = fault_mask_ff[`CIMC_B_OVP];
    assign block_vec[`CIMC_EV_TSHUT]  = fault_mask_ff[`CIMC_B_TSHUT];
    assign block_vec[`CIMC_EV_BATOVP] = fault_mask_ff[`CIMC_B_BATOVP];
    assign block_vec[`CIMC_EV_TMR]    = fault_mask_ff[`CIMC_B_TMR];
    assign block_vec[`CIMC_EV_SHORT]  = fault_mask_ff[`CIMC_B_SHORT];
    assign block_vec[`CIMC_EV_BUCK]   = fault_mask_ff[`CIMC_B_BUCK];

    // Flags are sticky and cleared only by reset; the flag register event_seen lives in this block
    always @(posedge clk_sys) begin
        if (!rstn || reg_reset) begin
            irq_pulse  <= 1'b0;
            event_seen <= 11'h000;
        end else begin
            irq_pulse  <= |(event_pulse & ~block_vec);
            event_seen <= event_seen | event_pulse;
        end
    end

endmodule

`default_nettype wire

// ---- tb/cimc_bank_chk.sv ----
// Assertion checker for the charger mask and converter control bank.
// Assumes it is bound to cimc_bank and sees only that module's ports.
`default_nettype none
module cimc_bank_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Requests
    input wire logic        reg_reset,
    input wire logic        watchdog_expired,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    // Results
    input wire logic [7:0]  reg_rdata,
    input wire logic        irq_pulse,
    input wire logic [10:0] event_seen,
    input wire logic        conv_enable,
    input wire logic        conv_one_shot,
    input wire logic [3:0]  conv_resolution,
    input wire logic [7:0]  chan_off
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Read-back shape
    a_resv_mask_two: assert property (reg_addr == 8'h13 |-> reg_rdata[6:5] == 2'b00 && !reg_rdata[3])
        else $error("reserved bit set in mask two");
    a_resv_fault:    assert property (reg_addr == 8'h14 |-> reg_rdata[2:1] == 2'b00)
        else $error("reserved bit set in fault mask");
    a_resv_ctrl:     assert property (reg_addr == 8'h15 |-> reg_rdata[3:0] == 4'h0)
        else $error("reserved bit set in control");
    a_chan_resv_one: assert property (reg_addr == 8'h16 |-> reg_rdata[1])
        else $error("channel reserved bit not one");
    a_chan_mirror:   assert property (reg_addr == 8'h16 |-> chan_off == (reg_rdata & 8'hFD))
        else $error("channel outputs differ from register");
    a_res_decode:    assert property (reg_addr == 8'h15 |-> conv_resolution == 4'hF - reg_rdata[5:4])
        else $error("resolution decode wrong");
    a_ctrl_outputs:  assert property (reg_addr == 8'h15 |-> {conv_enable, conv_one_shot} == reg_rdata[7:6])
        else $error("control outputs differ from register");
    // ==========================================================
    // Updates
    a_wd_clears_en:  assert property (watchdog_expired |=> !conv_enable)
        else $error("enable survived watchdog");
    a_wd_keeps_rest: assert property (watchdog_expired && !reg_reset && !reg_wr |=>
        $stable(conv_one_shot) && $stable(conv_resolution))
        else $error("watchdog touched other control fields");
    a_mask_written:  assert property (reg_wr && reg_addr == 8'h14 && !reg_reset |=>
        reg_addr != 8'h14 || reg_rdata == ($past(reg_wdata) & 8'hF9))
        else $error("fault mask write lost");
    a_reset_clears:  assert property (reg_reset |=> event_seen == 11'h000 && conv_resolution == 4'hC)
        else $error("register reset incomplete");
    c_wd_hit:  cover property (watchdog_expired && conv_enable);
    c_irq:     cover property (irq_pulse);
    c_reg_rst: cover property (reg_reset);
endmodule
bind cimc_bank cimc_bank_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_reset(reg_reset),
    .watchdog_expired(watchdog_expired), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq_pulse(irq_pulse), .event_seen(event_seen), .conv_enable(conv_enable),
    .conv_one_shot(conv_one_shot), .conv_resolution(conv_resolution), .chan_off(chan_off));
`default_nettype wire

// ---- tb/cimc_host.sv ----
// Host side of the byte register port.
// Assumes read data is combinational from the address and writes land on the strobe edge.
`default_nettype none
module cimc_host (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Strobe lasts one cycle; stale data is inverted so it is never mistaken for live data
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        d = reg_rdata;
        reg_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the charger mask and converter control bank.
// Assumes the host model drives the register port and the bench drives status pins.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int pin; logic [7:0] a; int b; int ev; int both;} cimc_row_t;
    // Pin index, mask register, mask bit, flag index, falling edge also counts
    cimc_row_t  rows [11] = '{'{14, 8'h13, 7, 0, 1}, '{11, 8'h13, 4, 1, 1}, '{8, 8'h13, 2, 2, 1},
        '{7, 8'h13, 1, 3, 0}, '{6, 8'h13, 0, 4, 1}, '{5, 8'h14, 7, 5, 0}, '{4, 8'h14, 6, 6, 0},
        '{3, 8'h14, 5, 7, 0}, '{2, 8'h14, 4, 8, 0}, '{1, 8'h14, 3, 9, 0}, '{0, 8'h14, 0, 10, 0}};
    logic [7:0] ra [4] = '{8'h13, 8'h14, 8'h15, 8'h16};
    logic [7:0] rv [4] = '{8'h00, 8'h00, 8'h30, 8'h02};
    logic [7:0] fv [4] = '{8'h97, 8'hF9, 8'hF0, 8'hFF};
    logic        clk_sys, rstn, rr, wd, reg_wr, reg_rd, reg_hit, irq_pulse, conv_enable, conv_one_shot;
    logic [14:0] st;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, chan_off, d;
    logic [10:0] event_seen;
    logic [3:0]  conv_resolution;
    int          errors, comparisons, nirq;
    cimc_host u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    cimc_bank u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_reset(rr), .watchdog_expired(wd),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .power_good(st[14]), .input_bus_state(st[13:11]),
        .thermistor_state(st[10:8]), .optimizer_state(st[7]), .min_system_voltage(st[6]),
        .input_overvolt(st[5]), .thermal_shutdown(st[4]), .battery_overvolt(st[3]),
        .safety_timer_expired(st[2]), .system_short(st[1]), .buck_fault_state(st[0]),
        .irq_pulse(irq_pulse), .event_seen(event_seen), .conv_enable(conv_enable),
        .conv_one_shot(conv_one_shot), .conv_resolution(conv_resolution), .chan_off(chan_off));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (irq_pulse === 1'b1) nirq <= nirq + 1;
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Two sync flops plus the registered pulse fit well inside six cycles
    task flip(input int p, input int e);
        int n0;
        @(posedge clk_sys);
        st[p] <= ~st[p];
        n0 = nirq;
        repeat (6) @(posedge clk_sys);
        chk("irq count", e, nirq - n0);
    endtask
    task results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        results();
    end
    initial begin
        rstn = 1'b0; rr = 1'b0; wd = 1'b0; st = 15'h0000; errors = 0; comparisons = 0; nirq = 0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        // ==========================================================
        // Event table: masked rise and fall, then unmasked rise and fall
        for (int i = 0; i < 11; i++) begin
            u_host.wr(rows[i].a, 8'h01 << rows[i].b);
            flip(rows[i].pin, 0);
            chk("event flag", 1, event_seen[rows[i].ev]);
            flip(rows[i].pin, 0);
            u_host.wr(rows[i].a, 8'h00);
            flip(rows[i].pin, 1);
            flip(rows[i].pin, rows[i].both);
            $display("event row %0d done", i);
        end
        // ==========================================================
        // Register reset, access kinds, unmapped index
        rr <= 1'b1;
        @(posedge clk_sys);
        rr <= 1'b0;
        @(posedge clk_sys);
        chk("flags", 0, event_seen);
        for (int k = 0; k < 4; k++) begin
            u_host.rd(ra[k], d);
            chk("reset value", rv[k], d);
            chk("hit", 1, reg_hit);
            u_host.wr(ra[k], 8'hFF);
            u_host.rd(ra[k], d);
            chk("all ones", fv[k], d);
        end
        chk("channel off", 16'h00FD, chan_off);
        u_host.wr(8'h17, 8'hFF);
        u_host.rd(8'h17, d);
        chk("unmapped", 0, d);
        chk("hit", 0, reg_hit);
        $display("register access done");
        // ==========================================================
        // Sample speed codes, watchdog, mid-run reset
        for (int k = 0; k < 4; k++) begin
            u_host.wr(8'h15, {2'b10, k[1:0], 4'h0});
            u_host.rd(8'h15, d);
            chk("control", {2'b10, k[1:0], 4'h0}, d);
            chk("resolution", 15 - k, conv_resolution);
        end
        u_host.wr(8'h15, 8'hC0);
        wd <= 1'b1;
        @(posedge clk_sys);
        wd <= 1'b0;
        u_host.rd(8'h15, d);
        chk("after watchdog", 8'h40, d);
        // Watchdog in the same cycle as a control write must still clear the enable
        fork
            u_host.wr(8'h15, 8'hC0);
            begin
                @(posedge clk_sys);
                wd <= 1'b1;
                @(posedge clk_sys);
                wd <= 1'b0;
            end
        join
        u_host.rd(8'h15, d);
        chk("watchdog beats write", 8'h40, d);
        chk("enable", 0, conv_enable);
        chk("one shot", 1, conv_one_shot);
        u_host.rd(8'h14, d);
        chk("mask kept", 8'hF9, d);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        u_host.rd(8'h15, d);
        chk("control reset", 8'h30, d);
        $display("control tests done");
        results();
    end
endmodule
`default_nettype wire
